// ===== logic/gain_channel.v
`timescale 1ns/1ps
`include "spk_gain_defs.vh"
// one channel: holds pending gain and applies it on trigger
module gain_channel (
    // clock and reset
    input wire mclk,
    input wire rst,
    // control
    input wire [5:0] stored_gain,
    input wire zc_enable,
    input wire apply,
    input wire zero_cross,
    input wire timeout,
    // status
    output reg [5:0] gain_r,
    output reg pending_r
);
    // apply now, or wait for crossing or timeout
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_r <= `RST_GAIN;
            pending_r <= 1'b0;
        end else if (apply && !zc_enable) begin
            gain_r <= stored_gain; // R5
            pending_r <= 1'b0;
        end else if (apply) begin
            pending_r <= 1'b1; // R5
        end else if (pending_r && (zero_cross || timeout || !zc_enable)) begin
            gain_r <= stored_gain; // R18
            pending_r <= 1'b0;
        end
    end
endmodule

// ===== logic/speaker_path_gain_control.v
`timescale 1ns/1ps
`include "spk_gain_defs.vh"
// Overview of operation
// [R1] right mixer sums each of seven sources only while its select bit is set
// [R2] per-path attenuation bit gives -6dB on the right mixer inputs; code stores it for bits 0-3 and 6 only
// [R3] each amplifier takes gain from own six-bit code, -57dB plus code dB
// [R4] volume codes reset to 0x39, which is 0dB
// [R5] zero-cross enable defers gain change to crossing, else immediate
// [R6] pending change applies at timeout when no crossing came first
// [R7] volume write without apply bit stores value, gain unchanged
// [R8] apply bit in either volume register updates both channels together
// [R9] software keeps system clock running while writing apply bits
// [R10] amplifier silence bit mutes amplifier, resets to 1
// [R11] output silence bits 9 right, 8 left mute outputs, reset 1
// [R12] aux one direct to left output only while bit 8 set, reset 0
// [R13] direct aux route has fixed gain, unaffected by amp volume and mute
// [R14] each speaker output mixer path has selectable -6dB attenuation; code has it on right mixer bits 0-3 and 6 only
// [R15] software configures aux one pin for audio before use
// [R16] right mixer output muted while power bit 5 set, reset 1
// [R17] left amplifier feeds left output only while bit 7 set, reset 0
// [R18] each channel applies its pending gain at own crossing or timeout
module speaker_path_gain_control #(
    parameter TIMEOUT_TICKS = `TIMEOUT_TICKS
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // register port
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    output reg [15:0] reg_rdata,
    // analogue-side status
    input wire left_zero_cross,
    input wire right_zero_cross,
    input wire timeout_tick_enable,
    // mixer controls
    output wire [6:0] right_mix_select,
    output wire [6:0] right_mix_halving,
    output wire right_mixer_silence,
    output wire left_amp_to_output_select,
    output wire aux_one_direct_left_select,
    // amplifier controls
    output wire [5:0] left_amp_gain_code,
    output wire [5:0] right_amp_gain_code,
    output wire left_amp_silence,
    output wire right_amp_silence,
    output wire left_output_silence,
    output wire right_output_silence,
    output wire left_gain_pending,
    output wire right_gain_pending
);
    reg [15:0] out_mute_r;
    reg [15:0] lmix_r;
    reg [15:0] rmix_r;
    reg [15:0] ratt_r;
    reg [15:0] lvol_r;
    reg [15:0] rvol_r;
    reg [31:0] tmo_cnt_r;
    reg apply_r;
    wire tmo_pulse;
    wire wr_l;
    wire wr_r;

    // which volume register a write hits
    assign wr_l = reg_wr && (reg_addr == `REG_LVOL);
    assign wr_r = reg_wr && (reg_addr == `REG_RVOL);

    // register writes; apply bit is write-only
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_mute_r <= `RST_OUT_MUTE; // R11 R16
            lmix_r <= `RST_MIX; // R12 R17
            rmix_r <= `RST_MIX; // R1
            ratt_r <= `RST_MIX;
            lvol_r <= `RST_VOL; // R4 R10
            rvol_r <= `RST_VOL; // R4 R10
            apply_r <= 1'b0;
        end else begin
            apply_r <= (wr_l || wr_r) && reg_wdata[`B_APPLY]; // R8
            if (reg_wr) begin
                case (reg_addr)
                    `REG_OUT_MUTE: out_mute_r <= reg_wdata & 16'h0320; // R11 R16
                    `REG_LMIX_SEL: lmix_r <= reg_wdata & 16'h0180;
                    `REG_RMIX_SEL: rmix_r <= reg_wdata & 16'h007f;
                    `REG_RMIX_ATT: ratt_r <= reg_wdata & 16'h004f; // R2
                    `REG_LVOL: lvol_r <= reg_wdata & 16'h00ff; // R7
                    `REG_RVOL: rvol_r <= reg_wdata & 16'h00ff; // R7
                    default: ;
                endcase
            end
        end
    end

    // read back, unmapped reads zero
    always @* begin
        case (reg_addr)
            `REG_OUT_MUTE: reg_rdata = out_mute_r;
            `REG_LMIX_SEL: reg_rdata = lmix_r;
            `REG_RMIX_SEL: reg_rdata = rmix_r;
            `REG_RMIX_ATT: reg_rdata = ratt_r;
            `REG_LVOL: reg_rdata = lvol_r;
            `REG_RVOL: reg_rdata = rvol_r;
            default: reg_rdata = 16'h0000;
        endcase
    end

    // timeout counter, restarts on each apply
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmo_cnt_r <= 32'h0;
        end else if (apply_r || !timeout_tick_enable) begin
            tmo_cnt_r <= 32'h0;
        end else if (tmo_cnt_r != TIMEOUT_TICKS) begin
            tmo_cnt_r <= tmo_cnt_r + 32'h1;
        end
    end
    assign tmo_pulse = (tmo_cnt_r == TIMEOUT_TICKS - 1); // R6

    // per-channel gain application
    gain_channel u_left (
        .mclk(mclk),
        .rst(rst),
        .stored_gain(lvol_r[5:0]),
        .zc_enable(lvol_r[`B_ZC]),
        .apply(apply_r),
        .zero_cross(left_zero_cross),
        .timeout(tmo_pulse),
        .gain_r(left_amp_gain_code), // R3
        .pending_r(left_gain_pending)
    );
    gain_channel u_right (
        .mclk(mclk),
        .rst(rst),
        .stored_gain(rvol_r[5:0]),
        .zc_enable(rvol_r[`B_ZC]),
        .apply(apply_r),
        .zero_cross(right_zero_cross),
        .timeout(tmo_pulse),
        .gain_r(right_amp_gain_code), // R3
        .pending_r(right_gain_pending)
    );

    // control fields out to the analogue path
    assign right_mix_select = rmix_r[6:0]; // R1
    assign right_mix_halving = ratt_r[6:0]; // R2 R14
    assign right_mixer_silence = out_mute_r[`B_RMIX_SILENCE]; // R16
    assign left_amp_to_output_select = lmix_r[`B_LAMP_TO_OUT]; // R17
    assign aux_one_direct_left_select = lmix_r[`B_FIRST_AUXILIARY_INPUT_DIRECT]; // R12 R13
    assign left_amp_silence = lvol_r[`B_AMP_SILENCE]; // R10
    assign right_amp_silence = rvol_r[`B_AMP_SILENCE]; // R10
    assign left_output_silence = out_mute_r[`B_LOUT_SILENCE]; // R11
    assign right_output_silence = out_mute_r[`B_ROUT_SILENCE]; // R11
endmodule

// ===== logic/spk_gain_defs.vh
`ifndef SPK_GAIN_DEFS_VH
`define SPK_GAIN_DEFS_VH
// register indices on the control port
`define REG_OUT_MUTE 7'h03
`define REG_LMIX_SEL 7'h2b
`define REG_RMIX_SEL 7'h2c
`define REG_RMIX_ATT 7'h2e
`define REG_LVOL 7'h2f
`define REG_RVOL 7'h30
// field positions
`define B_RMIX_SILENCE 5
`define B_LOUT_SILENCE 8
`define B_ROUT_SILENCE 9
`define B_LAMP_TO_OUT 7
`define B_FIRST_AUXILIARY_INPUT_DIRECT 8
`define B_APPLY 8
`define B_ZC 7
`define B_AMP_SILENCE 6
// reset values
`define RST_OUT_MUTE 16'h0320
`define RST_MIX 16'h0000
`define RST_VOL 16'h0079
`define RST_GAIN 6'h39
// timeout in ms and its tick count at 100 MHz
`define TIMEOUT_MS 16
`define CLK_KHZ 100000
`define TIMEOUT_TICKS (`TIMEOUT_MS * `CLK_KHZ)
`endif

// ===== test/spk_gain_props.sv
`timescale 1ns/1ps
module spk_gain_props #(parameter int TIMEOUT_TICKS = 20) (
    // clock, reset, writes
    input wire mclk, rst, reg_wr,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    // watched controls
    input wire [6:0] right_mix_select, right_mix_halving,
    input wire [5:0] left_amp_gain_code,
    input wire left_amp_silence, left_output_silence, right_output_silence,
    input wire left_zero_cross, timeout_tick_enable, left_gain_pending, right_gain_pending
);
    localparam int TO_MAX = TIMEOUT_TICKS + 4;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // write decodes
    wire wl = reg_wr && reg_addr == 7'h2f;
    wire [15:0] d = reg_wdata;
    AST_SEL: assert property (reg_wr && reg_addr == 7'h2c
        |=> right_mix_select == $past(d[6:0])) else $error("select not stored");
    AST_HALF: assert property (reg_wr && reg_addr == 7'h2e
        |=> right_mix_halving == ($past(d[6:0]) & 7'h4f)) else $error("halving wrong");
    AST_NOW: assert property (wl && d[8] && !d[7]
        |=> ##1 left_amp_gain_code == $past(d[5:0], 2)) else $error("gain not applied");
    AST_AMUTE: assert property (wl
        |=> left_amp_silence == $past(d[6])) else $error("amp silence wrong");
    AST_OMUTE: assert property (reg_wr && reg_addr == 7'h03
        |=> {right_output_silence, left_output_silence} == $past(d[9:8])) else $error("out mute");
    AST_ZC: assert property (left_gain_pending && left_zero_cross && !reg_wr && !$past(reg_wr)
        |=> !left_gain_pending) else $error("crossing ignored");
    AST_HOLD: assert property (left_gain_pending && !left_zero_cross && !timeout_tick_enable
        && !reg_wr && !$past(reg_wr) |=> $stable(left_amp_gain_code)) else $error("early gain");
    AST_TMO: assert property ($rose(timeout_tick_enable) && right_gain_pending
        |-> ##[1:TO_MAX] !right_gain_pending) else $error("timeout missed");
    // main scenarios
    cover property (left_gain_pending && left_zero_cross);
    cover property ($fell(right_gain_pending));
    cover property (wl && d[8]);
endmodule
bind speaker_path_gain_control spk_gain_props #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) p (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .right_mix_select(right_mix_select), .right_mix_halving(right_mix_halving),
    .left_amp_gain_code(left_amp_gain_code), .left_amp_silence(left_amp_silence),
    .left_output_silence(left_output_silence), .right_output_silence(right_output_silence),
    .left_zero_cross(left_zero_cross), .timeout_tick_enable(timeout_tick_enable),
    .left_gain_pending(left_gain_pending), .right_gain_pending(right_gain_pending));

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    reg mclk = 0, rst = 1, reg_wr = 0, zl = 0, zr = 0, tk = 0;
    reg [6:0] reg_addr = 0, a;
    reg [15:0] reg_wdata = 0, d;
    reg [5:0] el, er, nl, nr;
    wire [15:0] reg_rdata;
    wire [6:0] sel, hlv;
    wire [5:0] gl, gr;
    wire rms, lao, aux, las, ras, los, ros, pl, pr;
    integer miscompares = 0, n_tests = 0, i, k;
    `define CHK(n, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
        miscompares = miscompares + 1; $display("MISMATCH %s exp %h got %h", n, e, g); end end
    speaker_path_gain_control #(.TIMEOUT_TICKS(20)) DUT (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .left_zero_cross(zl), .right_zero_cross(zr), .timeout_tick_enable(tk),
        .right_mix_select(sel), .right_mix_halving(hlv), .right_mixer_silence(rms),
        .left_amp_to_output_select(lao), .aux_one_direct_left_select(aux),
        .left_amp_gain_code(gl), .right_amp_gain_code(gr), .left_amp_silence(las),
        .right_amp_silence(ras), .left_output_silence(los), .right_output_silence(ros),
        .left_gain_pending(pl), .right_gain_pending(pr));
    initial forever #5 mclk = ~mclk;
    // readable bits of the mute and mixer registers
    function [15:0] msk(input [6:0] x);
        case (x)
            7'h03: msk = 16'h0320;
            7'h2b: msk = 16'h0180;
            7'h2c: msk = 16'h007f;
            7'h2e: msk = 16'h004f;
            default: msk = 16'h0000;
        endcase
    endfunction
    // one write, taken at the second edge
    task wr(input [6:0] x, input [15:0] v);
        begin
            @(posedge mclk);
            reg_addr <= x;
            reg_wdata <= v;
            reg_wr <= 1;
            @(posedge mclk);
            reg_wr <= 0;
        end
    endtask
    // pass n edges, sample mid-cycle
    task at(input integer n);
        begin
            repeat (n) @(posedge mclk);
            @(negedge mclk);
        end
    endtask
    task rd(input [6:0] x, input [15:0] e);
        begin
            @(posedge mclk);
            reg_addr <= x;
            at(0);
            `CHK("rdata", e, reg_rdata)
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        void'($urandom(19));
        repeat (3) @(posedge mclk);
        rst <= 0;
        rd(7'h03, 16'h0320);
        rd(7'h2f, 16'h0079);
        `CHK("gain", 6'h39, gr)
        `CHK("amp mute", 2'b11, {las, ras})
        `CHK("out mute", 3'b111, {rms, los, ros})
        `CHK("left sel", 2'b00, {lao, aux})
        `CHK("rmix sel", 14'h0000, {sel, hlv})
        $display("reset test done");
        for (i = 0; i < 25; i = i + 1) begin
            k = i % 5;
            a = (k == 4) ? 7'h03 : 7'h2b + k;
            d = $urandom;
            wr(a, d);
            rd(a, d & msk(a));
        end
        wr(7'h2c, 16'hffff);
        wr(7'h2e, 16'hffff);
        wr(7'h03, 16'h0000);
        wr(7'h2b, 16'h0180);
        at(0);
        `CHK("select out", 7'h7f, sel)
        `CHK("halving out", 7'h4f, hlv)
        `CHK("out unmute", 3'b000, {rms, los, ros})
        `CHK("left route", 2'b11, {lao, aux})
        `CHK("aux route", 1'b1, aux)
        wr(7'h2f, 16'h0000);
        wr(7'h30, 16'h0000);
        at(0);
        `CHK("amp unmute", 2'b00, {las, ras})
        $display("register test done");
        el = $urandom;
        er = $urandom;
        wr(7'h30, {10'h000, er});
        at(2);
        `CHK("gain", 6'h39, gr)
        wr(7'h2f, 16'h0100 | el);
        at(2);
        `CHK("left gain", el, gl)
        `CHK("right gain", er, gr)
        rd(7'h2f, {10'h000, el});
        $display("apply test done");
        nl = $urandom;
        nr = $urandom;
        wr(7'h30, 16'h0080 | nr);
        wr(7'h2f, 16'h0180 | nl);
        at(2);
        `CHK("pending", 2'b11, {pl, pr})
        `CHK("held gain", el, gl)
        @(posedge mclk);
        zl <= 1;
        @(posedge mclk);
        zl <= 0;
        at(1);
        `CHK("left gain", nl, gl)
        `CHK("right pending", 1'b1, pr)
        @(posedge mclk);
        tk <= 1;
        k = 0;
        while (pr !== 1'b0 && k < 100) begin
            @(posedge mclk);
            k = k + 1;
        end
        if (k == 100) miscompares = miscompares + 1;
        at(0);
        `CHK("right gain", nr, gr)
        $display("zero cross test done");
        test_done;
    end
endmodule
